// ### design/tsio_pkg.sv
// Shared constants and types for the trigger-output and sync I/O block
package tsio_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int LEN_W = 16;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_IO_CFG = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_GROUP_DEPTH = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_LOCAL_DEPTH = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_GROUP_SIZE = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h18;
  // Control register fields
  localparam int CTRL_SYNC_EN = 0;
  localparam int CTRL_CLK_MASTER = 1;
  localparam int CTRL_TRIG_SOURCE = 2;
  localparam int CTRL_STAR_EN = 3;
  localparam int CTRL_AUTO_REARM = 4;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  // Command register fields (write-one pulses)
  localparam int CMD_ARM = 0;
  localparam int CMD_FORCE = 1;
  localparam int CMD_FORCE_EXT = 2;
  localparam int CMD_DISARM = 3;
  // I/O configuration fields
  localparam int IO_SEL_W = 3;
  localparam int IO_A_LSB = 0;
  localparam int IO_B_LSB = 4;
  // Status fields
  localparam int ST_ARMED = 0;
  localparam int ST_ACQ = 1;
  localparam int ST_TRIG_OUT = 2;
  localparam int ST_SYNC_ACTIVE = 3;
  localparam int ST_IO_A_IN = 4;
  localparam int ST_IO_B_IN = 5;
  localparam int ST_SIZE_ERR = 6;
  // Group size limits per form factor
  localparam int GROUP_SIZE_W = 3;
  localparam logic [GROUP_SIZE_W-1:0] MAX_GROUP_LARGE = 3'h5;
  localparam logic [GROUP_SIZE_W-1:0] MAX_GROUP_SMALL = 3'h3;
  localparam logic [GROUP_SIZE_W-1:0] GROUP_SIZE_RST = 3'h1;
  // Timing
  localparam int CLK_NS = 10;
  localparam int REF_OUT_MHZ = 10;
  localparam int REF_HALF_CYC = (1000 / REF_OUT_MHZ) / 2 / CLK_NS;
  localparam int LINK_PERIOD_NS = 120;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / 2 / CLK_NS;
  localparam int DIV_W = 4;
  typedef enum logic [IO_SEL_W-1:0] {
    IO_HIZ, IO_TRIG_EN, IO_REF_10M, IO_SEG_SKIP, IO_ACQ_ACTIVE, IO_ARMED
  } tsio_io_sel_e;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_TRIG, ST_ACQUIRE} tsio_state_e;
endpackage

// ### design/tsio_sync2.sv
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
module tsio_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  if (WIDTH < 1) begin : g_width_chk
    $error("WIDTH must be at least one");
  end
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule

// ### design/tsio_io_line.sv
// One configurable front-panel I/O line: output selector and driver enable
`timescale 1ns/1ns
module tsio_io_line
  import tsio_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Function select
  input wire logic [tsio_pkg::IO_SEL_W-1:0] sel,
  // Status sources
  input wire logic ref_10m,
  input wire logic seg_skip,
  input wire logic acq_active,
  input wire logic armed,
  // Pin driver
  output logic pin_o,
  output logic pin_oe
);
  logic o_q;
  logic o_d;
  logic oe_q;
  logic oe_d;

  always_comb begin
    o_d = 1'b0;
    oe_d = 1'b1;
    case (tsio_io_sel_e'(sel))
      IO_REF_10M: o_d = ref_10m;
      IO_SEG_SKIP: o_d = seg_skip;
      IO_ACQ_ACTIVE: o_d = acq_active;
      IO_ARMED: o_d = armed;
      default: oe_d = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      o_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      o_q <= o_d;
      oe_q <= oe_d;
    end
  end

  assign pin_o = o_q;
  assign pin_oe = oe_q;
endmodule

// ### design/tsio_top.sv
// Trigger output, configurable I/O lines and multi-module sync logic
//
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
module tsio_top
  import tsio_pkg::*;
#(
  parameter logic [tsio_pkg::LEN_W-1:0] LOCAL_DEPTH = 16'h0400,
  parameter bit LARGE_FORM = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [tsio_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [tsio_pkg::DATA_W-1:0] avs_writedata,
  output logic [tsio_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Hardware trigger from the trigger comparator
  input wire logic hw_trig_pin,
  // Trigger output and star line
  output logic trigger_out_pin,
  output logic pxi_star_o,
  output logic pxi_star_oe,
  // Configurable I/O lines
  input wire logic io_a_i,
  output logic io_a_o,
  output logic io_a_oe,
  input wire logic io_b_i,
  output logic io_b_o,
  output logic io_b_oe,
  // Inter-module sync bus
  input wire logic sync_clk_i,
  output logic sync_clk_o,
  output logic sync_clk_oe,
  input wire logic sync_trig_i,
  output logic sync_trig_o,
  output logic sync_trig_oe,
  // Sample strobe for the acquisition datapath
  output logic sample_en
);
  if (LOCAL_DEPTH == '0) begin : g_depth_chk
    $error("LOCAL_DEPTH must be non-zero");
  end
  // Synchronised pins: trigger, io_a, io_b, bus clock, bus trigger
  logic [4:0] pins_s;
  tsio_sync2 #(.WIDTH(5), .RST_VAL(5'h06)) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_i({sync_trig_i, sync_clk_i, io_b_i, io_a_i, hw_trig_pin}),
    .sync_o(pins_s)
  );
  logic hw_trig_s, io_a_s, io_b_s, bus_clk_s, bus_trig_s;
  assign {bus_trig_s, bus_clk_s, io_b_s, io_a_s, hw_trig_s} = pins_s;
  // Registers
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [IO_SEL_W-1:0] sel_a_q, sel_a_d;
  logic [IO_SEL_W-1:0] sel_b_q, sel_b_d;
  logic [LEN_W-1:0] group_depth_q, group_depth_d;
  logic [GROUP_SIZE_W-1:0] group_size_q, group_size_d;
  logic ack_q, ack_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic cmd_arm, cmd_force, cmd_force_ext, cmd_disarm;
  logic [DATA_W-1:0] status_w;
  // Trigger state
  tsio_state_e state_q, state_d;
  logic trig_out_q, trig_out_d;
  logic [LEN_W-1:0] cnt_q, cnt_d;
  logic seg_skip_q, seg_skip_d;
  // Edge detection and dividers
  logic hw_trig_prev_q, bus_trig_prev_q, bus_clk_prev_q;
  logic [DIV_W-1:0] ref_div_q, ref_div_d;
  logic ref_10m_q, ref_10m_d;
  logic [DIV_W-1:0] link_div_q, link_div_d;
  logic link_clk_q, link_clk_d;
  // Group size limit for the form factor
  logic [GROUP_SIZE_W-1:0] max_group;
  logic size_err;
  assign max_group = LARGE_FORM ? MAX_GROUP_LARGE : MAX_GROUP_SMALL;
  assign size_err = (group_size_q > max_group) || (group_size_q == '0);
  // Sync only once software enables it
  logic sync_active;
  logic clk_master;
  logic trig_source;
  assign sync_active = ctrl_q[CTRL_SYNC_EN] && !size_err;
  assign clk_master = sync_active && ctrl_q[CTRL_CLK_MASTER];
  assign trig_source = sync_active && ctrl_q[CTRL_TRIG_SOURCE];
  // Effective length is the smaller depth when synchronised, else the local depth
  logic [LEN_W-1:0] acq_len;
  assign acq_len = (sync_active && group_depth_q < LOCAL_DEPTH) ? group_depth_q : LOCAL_DEPTH;
  // io_a and io_b synchronisers reset high, open line idles high
  logic trig_enabled;
  assign trig_enabled = (sel_a_q != IO_TRIG_EN || io_a_s) && (sel_b_q != IO_TRIG_EN || io_b_s);
  // Sample on the shared clock edge when synchronised
  logic link_rise;
  assign link_rise = (link_div_q == DIV_W'(LINK_HALF_CYC - 1)) && !link_clk_q;
  always_comb begin
    if (!sync_active) begin
      sample_en = 1'b1;
    end else if (clk_master) begin
      sample_en = link_rise;
    end else begin
      sample_en = bus_clk_s && !bus_clk_prev_q;
    end
  end
  // Trigger from own pin or from the group source
  logic hw_event;
  always_comb begin
    if (sync_active && !trig_source) begin
      hw_event = bus_trig_s && !bus_trig_prev_q;
    end else begin
      hw_event = hw_trig_s && !hw_trig_prev_q;
    end
  end
  // Bus slave: one wait cycle, then the access completes
  always_comb begin
    ack_d = (avs_read || avs_write) && !ack_q;
    status_w = '0;
    status_w[ST_ARMED] = (state_q == ST_WAIT_TRIG);
    status_w[ST_ACQ] = (state_q == ST_ACQUIRE);
    status_w[ST_TRIG_OUT] = trig_out_q;
    status_w[ST_SYNC_ACTIVE] = sync_active;
    status_w[ST_IO_A_IN] = io_a_s;
    status_w[ST_IO_B_IN] = io_b_s;
    status_w[ST_SIZE_ERR] = size_err;
    rdata_d = rdata_q;
    if (avs_read && !ack_q) begin
      rdata_d = '0;
      case (avs_address)
        ADDR_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
        ADDR_IO_CFG: begin
          rdata_d[IO_A_LSB +: IO_SEL_W] = sel_a_q;
          rdata_d[IO_B_LSB +: IO_SEL_W] = sel_b_q;
        end
        ADDR_GROUP_DEPTH: rdata_d[LEN_W-1:0] = group_depth_q;
        ADDR_LOCAL_DEPTH: rdata_d[LEN_W-1:0] = LOCAL_DEPTH;
        ADDR_GROUP_SIZE: rdata_d[GROUP_SIZE_W-1:0] = group_size_q;
        ADDR_STATUS: rdata_d = status_w;
        default: rdata_d = '0;
      endcase
    end
  end
  logic wr_en;
  assign wr_en = avs_write && ack_q;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rdata_q;
  assign cmd_arm = wr_en && avs_address == ADDR_CMD && avs_writedata[CMD_ARM];
  assign cmd_force = wr_en && avs_address == ADDR_CMD && avs_writedata[CMD_FORCE];
  assign cmd_force_ext = wr_en && avs_address == ADDR_CMD && avs_writedata[CMD_FORCE_EXT];
  assign cmd_disarm = wr_en && avs_address == ADDR_CMD && avs_writedata[CMD_DISARM];
  always_comb begin
    ctrl_d = ctrl_q;
    sel_a_d = sel_a_q;
    sel_b_d = sel_b_q;
    group_depth_d = group_depth_q;
    group_size_d = group_size_q;
    if (wr_en) begin
      case (avs_address)
        ADDR_CTRL: ctrl_d = avs_writedata[CTRL_W-1:0];
        ADDR_IO_CFG: begin
          sel_a_d = avs_writedata[IO_A_LSB +: IO_SEL_W];
          sel_b_d = avs_writedata[IO_B_LSB +: IO_SEL_W];
        end
        ADDR_GROUP_DEPTH: group_depth_d = avs_writedata[LEN_W-1:0];
        ADDR_GROUP_SIZE: group_size_d = avs_writedata[GROUP_SIZE_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q <= CTRL_RST;
      sel_a_q <= IO_HIZ;
      sel_b_q <= IO_HIZ;
      group_depth_q <= LOCAL_DEPTH;
      group_size_q <= GROUP_SIZE_RST;
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      sel_a_q <= sel_a_d;
      sel_b_q <= sel_b_d;
      group_depth_q <= group_depth_d;
      group_size_q <= group_size_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end
  // Trigger and acquisition sequencing
  always_comb begin
    state_d = state_q;
    trig_out_d = trig_out_q;
    cnt_d = cnt_q;
    seg_skip_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (cmd_arm) begin
          state_d = ST_WAIT_TRIG;
        end
      end
      ST_WAIT_TRIG: begin
        cnt_d = '0;
        if (cmd_disarm) begin
          state_d = ST_IDLE;
        end else if (cmd_force_ext || (hw_event && trig_enabled)) begin
          // Extended force behaves as hardware trigger
          state_d = ST_ACQUIRE;
          trig_out_d = 1'b1;
        end else if (cmd_force) begin
          state_d = ST_ACQUIRE;
        end
      end
      ST_ACQUIRE: begin
        if (sample_en) begin
          if (cnt_q == acq_len - LEN_W'(1)) begin
            trig_out_d = 1'b0;
            seg_skip_d = 1'b1;
            state_d = ctrl_q[CTRL_AUTO_REARM] ? ST_WAIT_TRIG : ST_IDLE;
          end else begin
            cnt_d = cnt_q + LEN_W'(1);
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        trig_out_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      trig_out_q <= 1'b0;
      cnt_q <= '0;
      seg_skip_q <= 1'b0;
    end else begin
      state_q <= state_d;
      trig_out_q <= trig_out_d;
      cnt_q <= cnt_d;
      seg_skip_q <= seg_skip_d;
    end
  end
  // Dividers: 10 MHz reference and bus clock when master
  always_comb begin
    ref_div_d = ref_div_q + DIV_W'(1);
    ref_10m_d = ref_10m_q;
    if (ref_div_q == DIV_W'(REF_HALF_CYC - 1)) begin
      ref_div_d = '0;
      ref_10m_d = !ref_10m_q;
    end
    link_div_d = link_div_q + DIV_W'(1);
    link_clk_d = link_clk_q;
    if (link_div_q == DIV_W'(LINK_HALF_CYC - 1)) begin
      link_div_d = '0;
      link_clk_d = !link_clk_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ref_div_q <= '0;
      ref_10m_q <= 1'b0;
      link_div_q <= '0;
      link_clk_q <= 1'b0;
      hw_trig_prev_q <= 1'b0;
      bus_trig_prev_q <= 1'b0;
      bus_clk_prev_q <= 1'b0;
    end else begin
      ref_div_q <= ref_div_d;
      ref_10m_q <= ref_10m_d;
      link_div_q <= link_div_d;
      link_clk_q <= link_clk_d;
      hw_trig_prev_q <= hw_trig_s;
      bus_trig_prev_q <= bus_trig_s;
      bus_clk_prev_q <= bus_clk_s;
    end
  end
  // Drive the shared clock and trigger onto the bus
  assign sync_clk_o = link_clk_q;
  assign sync_clk_oe = clk_master;
  assign sync_trig_o = trig_out_q;
  assign sync_trig_oe = trig_source;
  assign trigger_out_pin = trig_out_q;
  assign pxi_star_o = trig_out_q && ctrl_q[CTRL_STAR_EN];
  assign pxi_star_oe = ctrl_q[CTRL_STAR_EN];

  // Configurable I/O lines
  tsio_io_line u_io_a (
    .ref_clk(ref_clk),
    .srst(srst),
    .sel(sel_a_q),
    .ref_10m(ref_10m_q),
    .seg_skip(seg_skip_q),
    .acq_active(state_q == ST_ACQUIRE),
    .armed(state_q == ST_WAIT_TRIG),
    .pin_o(io_a_o),
    .pin_oe(io_a_oe)
  );

  tsio_io_line u_io_b (
    .ref_clk(ref_clk),
    .srst(srst),
    .sel(sel_b_q),
    .ref_10m(ref_10m_q),
    .seg_skip(seg_skip_q),
    .acq_active(state_q == ST_ACQUIRE),
    .armed(state_q == ST_WAIT_TRIG),
    .pin_o(io_b_o),
    .pin_oe(io_b_oe)
  );
endmodule

// ### dv/tsio_chk_assertions.sv
// Port-level checker for the trigger output and sync block
`timescale 1ns/1ns
module tsio_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Register bus
  input wire logic [tsio_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [tsio_pkg::DATA_W-1:0] avs_writedata,
  input wire logic avs_waitrequest,
  // Trigger and sync signals
  input wire logic hw_trig_pin,
  input wire logic sync_trig_i,
  input wire logic trigger_out_pin,
  input wire logic sample_en,
  input wire logic pxi_star_oe,
  input wire logic sync_trig_o,
  input wire logic sync_trig_oe,
  input wire logic sync_clk_oe,
  input wire logic sync_clk_o,
  input wire logic io_a_oe
);
  import tsio_pkg::*;
  logic [3:0] since_q;
  logic [3:0] since_d;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Cycles since anything that may start an acquisition
  always_comb begin
    since_d = since_q;
    if (avs_write || hw_trig_pin || sync_trig_i) since_d = 4'h0;
    else if (since_q != 4'hF) since_d = since_q + 4'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (srst) since_q <= 4'hF;
    else since_q <= since_d;
  end
  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered after one wait");
  trig_cause_a: assert property ($rose(trigger_out_pin) |-> since_q <= 4'h7)
    else $error("trigger out rose without a trigger");
  trig_hold_a: assert property ($rose(trigger_out_pin) |-> trigger_out_pin [*8])
    else $error("trigger out dropped too early");
  trig_drop_a: assert property ($fell(trigger_out_pin) |-> $past(sample_en))
    else $error("trigger out dropped without a sample strobe");
  master_strobe_a: assert property (sync_clk_oe && sample_en |=> $rose(sync_clk_o))
    else $error("strobe not aligned with the driven bus clock");
  star_oe_a: assert property ($rose(pxi_star_oe) |-> $past(avs_write) && $past(avs_address) == ADDR_CTRL)
    else $error("star line enabled without a control write");
  // Writes that may turn synchronised operation on
  logic en_wr;
  assign en_wr = avs_write && ((avs_address == ADDR_CTRL && avs_writedata[CTRL_SYNC_EN]) || avs_address == ADDR_GROUP_SIZE);
  sync_off_a: assert property ($rose(sync_clk_oe || sync_trig_oe) |-> $past(en_wr))
    else $error("sync bus driven without software enable");
  io_oe_a: assert property ($changed(io_a_oe) |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("io line direction changed without a write");
  acq_c: cover property ($fell(trigger_out_pin));
  star_c: cover property (pxi_star_oe && trigger_out_pin);
  strobe_c: cover property (!sample_en ##1 sample_en);
endmodule

// ### dv/tsio_peer.sv
// Neighbour module model: shared link clock and bus trigger source
`timescale 1ns/1ns
module tsio_peer (
  // Control from the bench
  input wire logic run,
  input wire logic fire,
  // Sync bus drive
  output logic link_clk,
  output logic link_trig
);
  initial begin
    link_clk = 1'b0;
    forever begin
      wait (run);
      #62 link_clk = 1'b1;
      #63 link_clk = 1'b0;
    end
  end
  initial link_trig = 1'b0;
  always @(posedge link_clk) link_trig <= fire;
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the trigger output and sync block
`timescale 1ns/1ns
module tb_top;
  import tsio_pkg::*;
  localparam logic [LEN_W-1:0] L = 16'h0010;
  logic ref_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, hw_trig_pin = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [DATA_W-1:0] avs_readdata, rd;
  logic avs_waitrequest, trigger_out_pin, pxi_star_o, pxi_star_oe, io_a_o, io_a_oe, io_b_o, io_b_oe;
  logic sync_clk_o, sync_clk_oe, sync_trig_o, sync_trig_oe, sample_en, peer_clk, peer_trig, seen;
  logic run = 1'b0, fire = 1'b0, ext_a = 1'b1;
  int fails = 0;
  int comparisons = 0;
  int c;
  // Wire levels from all drivers; io_b has a pull-up, io_a follows ext_a when released
  wire io_a_w = io_a_oe ? io_a_o : ext_a;
  wire io_b_w = io_b_oe ? io_b_o : 1'b1;
  wire sync_clk_w = sync_clk_oe ? sync_clk_o : peer_clk;
  wire sync_trig_w = sync_trig_oe ? sync_trig_o : peer_trig;
  always #5 ref_clk = ~ref_clk;
  tsio_top #(.LOCAL_DEPTH(L), .LARGE_FORM(1'b1)) i_tsio_top (.ref_clk(ref_clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hw_trig_pin(hw_trig_pin),
    .trigger_out_pin(trigger_out_pin), .pxi_star_o(pxi_star_o), .pxi_star_oe(pxi_star_oe), .io_a_i(io_a_w),
    .io_a_o(io_a_o), .io_a_oe(io_a_oe), .io_b_i(io_b_w), .io_b_o(io_b_o), .io_b_oe(io_b_oe),
    .sync_clk_i(sync_clk_w), .sync_clk_o(sync_clk_o), .sync_clk_oe(sync_clk_oe), .sync_trig_i(sync_trig_w),
    .sync_trig_o(sync_trig_o), .sync_trig_oe(sync_trig_oe), .sample_en(sample_en));
  tsio_peer i_tsio_peer (.run(run), .fire(fire), .link_clk(peer_clk), .link_trig(peer_trig));
  task automatic end_of_test();
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_up();
    fails++;
    $display("mismatch at %0t: wait timed out", $time);
    end_of_test();
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 20) give_up();
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdr(input logic [ADDR_W-1:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  // Counts sample strobes while trigger out stands
  task automatic strobes();
    int n;
    n = 0;
    c = 0;
    do begin
      @(negedge ref_clk);
      n++;
      if (n > 40) give_up();
    end while (trigger_out_pin !== 1'b1);
    while (trigger_out_pin === 1'b1) begin
      if (sample_en === 1'b1) c++;
      @(negedge ref_clk);
      n++;
      if (n > 900) give_up();
    end
    @(posedge ref_clk);
  endtask
  task automatic quiet();
    seen = 1'b0;
    repeat (30) begin
      @(negedge ref_clk);
      seen = seen | trigger_out_pin;
    end
    @(posedge ref_clk);
  endtask
  task automatic count_se(input int cyc);
    c = 0;
    repeat (cyc) begin
      @(negedge ref_clk);
      if (sample_en === 1'b1) c++;
    end
  endtask
  task automatic t_reset();
    chk(32'({trigger_out_pin, io_a_oe, io_b_oe, pxi_star_oe, sync_clk_oe, sync_trig_oe}), 32'h0);
    rdr(ADDR_STATUS);
    chk(32'(rd[ST_IO_B_IN:ST_IO_A_IN]), 32'h3);
    ext_a <= 1'b0;
    rdr(5'h1C);
    chk(rd, 32'h0);
    rdr(ADDR_STATUS);
    chk(32'(rd[ST_IO_A_IN]), 32'h0);
    ext_a <= 1'b1;
    rdr(ADDR_LOCAL_DEPTH);
    chk(rd, 32'(L));
  endtask
  task automatic t_trig();
    hw_trig_pin <= 1'b1;
    quiet();
    chk(32'(seen), 32'h0);
    hw_trig_pin <= 1'b0;
    wr(ADDR_CMD, 32'h1);
    hw_trig_pin <= 1'b1;
    strobes();
    hw_trig_pin <= 1'b0;
    chk(c, 32'(L));
    wr(ADDR_CMD, 32'h1);
    wr(ADDR_CMD, 32'h2);
    rdr(ADDR_STATUS);
    chk(32'(rd[ST_ACQ]), 32'h1);
    quiet();
    chk(32'(seen), 32'h0);
    wr(ADDR_CMD, 32'h1);
    wr(ADDR_CMD, 32'h4);
    strobes();
    chk(c, 32'(L));
  endtask
  task automatic t_io();
    for (int k = 0; k < 6; k++) begin
      wr(ADDR_IO_CFG, 32'((k << IO_B_LSB) | k));
      repeat (3) @(posedge ref_clk);
      chk(32'({io_a_oe, io_b_oe}), (k >= 2) ? 32'h3 : 32'h0);
    end
    wr(ADDR_CMD, 32'h1);
    repeat (3) @(posedge ref_clk);
    chk(32'({io_a_o, io_b_o}), 32'h3);
    wr(ADDR_IO_CFG, 32'h34);
    wr(ADDR_CMD, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk(32'(io_a_o), 32'h1);
    c = 0;
    repeat (30) begin
      @(negedge ref_clk);
      if (io_b_o === 1'b1) c++;
    end
    chk(c, 32'h1);
    wr(ADDR_CMD, 32'h8);
    wr(ADDR_IO_CFG, 32'h2);
    repeat (4) @(posedge ref_clk);
    seen = io_a_o;
    c = 0;
    repeat (100) begin
      @(negedge ref_clk);
      if (io_a_o !== seen) c++;
      seen = io_a_o;
    end
    chk(32'(c >= 19 && c <= 21), 32'h1);
    wr(ADDR_IO_CFG, 32'h1);
    ext_a <= 1'b0;
    wr(ADDR_CMD, 32'h1);
    hw_trig_pin <= 1'b1;
    quiet();
    chk(32'(seen), 32'h0);
    hw_trig_pin <= 1'b0;
    ext_a <= 1'b1;
    wr(ADDR_CMD, 32'h8);
  endtask
  task automatic t_sync();
    count_se(20);
    chk(c, 32'd20);
    run <= 1'b1;
    wr(ADDR_GROUP_DEPTH, 32'h4);
    wr(ADDR_CTRL, 32'h5);
    rdr(ADDR_STATUS);
    chk(32'(rd[ST_SYNC_ACTIVE]), 32'h1);
    count_se(125);
    chk(32'(c >= 9 && c <= 11), 32'h1);
    wr(ADDR_CMD, 32'h1);
    hw_trig_pin <= 1'b1;
    strobes();
    hw_trig_pin <= 1'b0;
    chk(32'(c >= 4 && c <= 5), 32'h1);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_CMD, 32'h1);
    fire <= 1'b1;
    strobes();
    fire <= 1'b0;
    chk(32'(c >= 4 && c <= 5), 32'h1);
    wr(ADDR_CTRL, 32'hD);
    wr(ADDR_CMD, 32'h1);
    wr(ADDR_CMD, 32'h4);
    @(negedge ref_clk);
    chk(32'({pxi_star_o, pxi_star_oe, sync_trig_oe, sync_trig_w}), 32'hF);
    strobes();
    wr(ADDR_GROUP_SIZE, 32'h6);
    rdr(ADDR_STATUS);
    chk(32'({rd[ST_SIZE_ERR], rd[ST_SYNC_ACTIVE]}), 32'h2);
    wr(ADDR_GROUP_SIZE, 32'h5);
    rdr(ADDR_STATUS);
    chk(32'({rd[ST_SIZE_ERR], rd[ST_SYNC_ACTIVE]}), 32'h1);
    run <= 1'b0;
    wr(ADDR_CTRL, 32'h3);
    count_se(125);
    chk(32'({sync_clk_oe, 1'(c >= 9 && c <= 11)}), 32'h3);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_trig();
    t_io();
    t_sync();
    end_of_test();
  end
endmodule
bind tsio_top tsio_chk i_tsio_chk (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .hw_trig_pin(hw_trig_pin), .sync_trig_i(sync_trig_i), .trigger_out_pin(trigger_out_pin),
  .sample_en(sample_en), .pxi_star_oe(pxi_star_oe), .sync_trig_o(sync_trig_o), .sync_trig_oe(sync_trig_oe),
  .sync_clk_oe(sync_clk_oe), .sync_clk_o(sync_clk_o), .io_a_oe(io_a_oe));
